// ---- core/csm_pkg.sv ----
/*
  Shared constants for the chip select and mode strap block.
  Assumes a 20-bit memory address space and a 16-bit register port.
*/
package csm_pkg;
  localparam int unsigned ADDR_W    = 20;
  localparam int unsigned REG_AW    = 4;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned NUM_MID   = 4;
  localparam int unsigned NUM_PER   = 7;
  localparam int unsigned PER_BLK_W = 7;

  localparam logic [19:0] UPPER_END   = 20'hF_FFFF;
  localparam logic [19:0] LOWER_START = 20'h0_0000;

  // Register indices; each size field is a 1 KB block count
  localparam logic [3:0] OFF_UPPER_SIZE = 4'h0;
  localparam logic [3:0] OFF_LOWER_SIZE = 4'h1;
  localparam logic [3:0] OFF_MID_BASE   = 4'h2;
  localparam logic [3:0] OFF_MID_SIZE   = 4'h3;
  localparam logic [3:0] OFF_PER_BASE   = 4'h4;
  localparam logic [3:0] OFF_CTRL       = 4'h5;
  localparam logic [3:0] OFF_WAIT       = 4'h6;
  localparam logic [3:0] OFF_STATUS     = 4'h7;
  localparam logic [3:0] OFF_MID_SEL    = 4'h8;

  localparam int unsigned CTRL_UPPER_EN = 0;
  localparam int unsigned CTRL_LOWER_EN = 1;
  localparam int unsigned CTRL_MID_EN   = 2;
  localparam int unsigned CTRL_PER_EN   = 3;
  localparam int unsigned CTRL_ADDR_OUT = 4;
  localparam int unsigned CTRL_REFRESH  = 5;
  localparam int unsigned CTRL_PWRSAVE  = 6;

  localparam int unsigned STAT_ENH   = 0;
  localparam int unsigned STAT_QUEUE = 1;
  localparam int unsigned STAT_FLOAT = 2;

  localparam logic [15:0] RST_UPPER_SIZE = 16'h0040;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_CTRL      = 16'h0001;
  localparam logic [3:0]  RST_WAIT      = 4'h3;
  localparam int unsigned KB_SHIFT      = 10;

  typedef enum logic [2:0] {
    ST_IN_RESET = 3'b001,
    ST_HOLD     = 3'b010,
    ST_RUN      = 3'b100
  } csm_strap_t;
endpackage

// ---- core/csm_range.sv ----
/*
  One address window compare: base plus size in 1 KB blocks.
  Assumes base and size are stable during a bus cycle.
*/
`timescale 1ns/1ns
module csm_range #(
  parameter int unsigned AW = 20
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] base,
  input  wire logic [15:0]   size_kb,
  input  wire logic          enable,
  output logic               hit
);
  logic [AW:0] span;
  logic [AW:0] top;
  assign span = {1'b0, size_kb[9:0], 10'h000};
  assign top  = {1'b0, base} + span;
  // Zero size never hits
  assign hit  = enable && (size_kb != 16'h0000)
             && ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
endmodule

// ---- core/csm_top.sv ----
/*
  Chip select decode and reset strap capture.
  Assumes bus cycle address, strobe and strap levels synchronous to sys_clk;
  strap pins read as high unless the board pulls them low.
*/
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module csm_top (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [15:0]               reg_rdata,
  input  wire logic [csm_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic                      bus_start,
  input  wire logic                      bus_is_mem,
  input  wire logic                      bus_is_dma,
  input  wire logic                      ext_ready,
  input  wire logic                      strap_busy_n,
  input  wire logic                      strap_rd_n,
  input  wire logic                      strap_upper_n,
  input  wire logic                      strap_lower_n,
  input  wire logic                      copro_req_in,
  input  wire logic                      copro_fault_n_in,
  input  wire logic                      numeric_sel_req,
  input  wire logic                      core_ale,
  input  wire logic                      core_wr_n,
  input  wire logic                      queue_status0,
  input  wire logic                      queue_status1,
  output logic                           upper_select_n,
  output logic                           lower_select_n,
  output logic      [3:0]                mid_sel_n,
  output logic      [6:0]                periph_select_n,
  output logic                           ale_pin,
  output logic                           wr_n_pin,
  output logic                           copro_req,
  output logic                           copro_fault,
  output logic                           bus_ready,
  output logic                           enhanced_mode,
  output logic                           queue_mode,
  output logic                           pin_float_test_mode,
  output logic                           refresh_enable,
  output logic                           power_save
);
  localparam int unsigned AW = csm_pkg::ADDR_W;
  typedef csm_pkg::csm_strap_t csm_strap_st_t;

  logic [15:0]      upper_size_reg;
  logic [15:0]      lower_size_reg;
  logic [15:0]      mid_base_reg [csm_pkg::NUM_MID];
  logic [15:0]      mid_size_reg [csm_pkg::NUM_MID];
  logic [15:0]      per_base_reg;
  logic [15:0]      ctrl_reg;
  logic [3:0]       wait_reg;
  logic             ext_rdy_reg;
  logic [1:0]       mid_idx_reg;
  csm_strap_st_t    strap_reg;
  logic             enh_reg;
  logic             queue_reg;
  logic             float_reg;

  // Reset strap capture on the first enabled edge after release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_reg <= csm_pkg::ST_IN_RESET;
      enh_reg   <= 1'b0;
      queue_reg <= 1'b0;
      float_reg <= 1'b0;
    end else if (clk_en) begin
      case (strap_reg)
        csm_pkg::ST_IN_RESET: begin
          enh_reg   <= !strap_busy_n;
          queue_reg <= !strap_rd_n;
          float_reg <= !strap_upper_n && !strap_lower_n;
          strap_reg <= csm_pkg::ST_HOLD;
        end
        csm_pkg::ST_HOLD: strap_reg <= csm_pkg::ST_RUN;
        csm_pkg::ST_RUN:  strap_reg <= csm_pkg::ST_RUN;
        default:          strap_reg <= csm_pkg::ST_IN_RESET;
      endcase
    end
  end

  logic enh_ok;
  logic wr_hit;
  assign enh_ok = enh_reg;
  assign wr_hit = reg_wr && clk_en;

  // Register writes; mid select indexed through a pointer register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      upper_size_reg <= csm_pkg::RST_UPPER_SIZE;
      lower_size_reg <= csm_pkg::RST_ZERO;
      per_base_reg   <= csm_pkg::RST_ZERO;
      ctrl_reg       <= csm_pkg::RST_CTRL;
      wait_reg       <= csm_pkg::RST_WAIT;
      ext_rdy_reg    <= 1'b0;
      mid_idx_reg    <= 2'b00;
      for (int i = 0; i < csm_pkg::NUM_MID; i++) begin
        mid_base_reg[i] <= csm_pkg::RST_ZERO;
        mid_size_reg[i] <= csm_pkg::RST_ZERO;
      end
    end else if (wr_hit) begin
      case (reg_addr)
        csm_pkg::OFF_UPPER_SIZE: upper_size_reg <= reg_wdata;
        csm_pkg::OFF_LOWER_SIZE: lower_size_reg <= reg_wdata;
        csm_pkg::OFF_MID_BASE:   mid_base_reg[mid_idx_reg] <= reg_wdata;
        csm_pkg::OFF_MID_SIZE:   mid_size_reg[mid_idx_reg] <= reg_wdata;
        csm_pkg::OFF_PER_BASE:   per_base_reg <= reg_wdata;
        csm_pkg::OFF_CTRL: begin
          ctrl_reg[4:0] <= reg_wdata[4:0];
          // Refresh and power-save bits are enhanced-only
          if (enh_ok) begin
            ctrl_reg[6:5] <= reg_wdata[6:5];
          end
        end
        csm_pkg::OFF_WAIT: begin
          wait_reg    <= reg_wdata[3:0];
          ext_rdy_reg <= reg_wdata[4];
        end
        csm_pkg::OFF_MID_SEL: mid_idx_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          csm_pkg::OFF_UPPER_SIZE: reg_rdata <= upper_size_reg;
          csm_pkg::OFF_LOWER_SIZE: reg_rdata <= lower_size_reg;
          csm_pkg::OFF_MID_BASE:   reg_rdata <= mid_base_reg[mid_idx_reg];
          csm_pkg::OFF_MID_SIZE:   reg_rdata <= mid_size_reg[mid_idx_reg];
          csm_pkg::OFF_PER_BASE:   reg_rdata <= per_base_reg;
          csm_pkg::OFF_CTRL:
            reg_rdata <= enh_ok ? ctrl_reg : {ctrl_reg[15:7], 2'b00, ctrl_reg[4:0]};
          csm_pkg::OFF_WAIT:       reg_rdata <= {11'h000, ext_rdy_reg, wait_reg};
          csm_pkg::OFF_STATUS:     reg_rdata <= {13'h0000, float_reg, queue_reg, enh_reg};
          csm_pkg::OFF_MID_SEL:    reg_rdata <= {14'h0000, mid_idx_reg};
          default:                 reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Region decode; no reference to bus_is_dma so both sources match alike
  logic [AW-1:0] upper_base;
  logic [AW:0]   upper_span;
  logic          upper_hit;
  logic          lower_hit;
  logic [3:0]    mid_hit;
  logic [6:0]    per_hit;
  logic [AW-1:0] per_base_addr;
  logic [AW-1:0] per_off;
  logic          mem_cyc;

  assign mem_cyc    = bus_is_mem;
  assign upper_span = {1'b0, upper_size_reg[9:0], 10'h000};
  assign upper_base = AW'(({1'b0, csm_pkg::UPPER_END} + 21'h0_0001) - upper_span);
  assign upper_hit  = ctrl_reg[csm_pkg::CTRL_UPPER_EN] && upper_size_reg != 16'h0000
                   && bus_addr >= upper_base;

  csm_range #(.AW(AW)) u_lower (
    .addr    (bus_addr),
    .base    (csm_pkg::LOWER_START),
    .size_kb (lower_size_reg),
    .enable  (ctrl_reg[csm_pkg::CTRL_LOWER_EN]),
    .hit     (lower_hit)
  );

  for (genvar g = 0; g < csm_pkg::NUM_MID; g++) begin : g_mid
    logic raw_hit;
    csm_range #(.AW(AW)) u_mid (
      .addr    (bus_addr),
      .base    ({mid_base_reg[g][9:0], 10'h000}),
      .size_kb (mid_size_reg[g]),
      .enable  (ctrl_reg[csm_pkg::CTRL_MID_EN]),
      .hit     (raw_hit)
    );
    // Mid windows yield to the fixed upper and lower regions
    assign mid_hit[g] = raw_hit && !upper_hit && !lower_hit;
  end

  assign per_base_addr = {per_base_reg[12:0], 7'h00};
  assign per_off       = bus_addr - per_base_addr;
  always_comb begin
    per_hit = 7'h00;
    if (ctrl_reg[csm_pkg::CTRL_PER_EN] && bus_addr >= per_base_addr
        && per_off < AW'(csm_pkg::NUM_PER << csm_pkg::PER_BLK_W)) begin
      per_hit[per_off[9:7]] = 1'b1;
    end
  end

  // Select pins registered at cycle start, held high if no match; periph pins 6:5 carry bus_addr[2:1] when CTRL_ADDR_OUT is set
  logic [3:0] mid_drive;
  logic [3:0] mid_now;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      upper_select_n  <= 1'b1;
      lower_select_n  <= 1'b1;
      mid_drive       <= 4'hF;
      periph_select_n <= 7'h7F;
    end else if (clk_en && bus_start) begin
      upper_select_n  <= !(mem_cyc && upper_hit);
      lower_select_n  <= !(mem_cyc && lower_hit);
      mid_drive       <= ~({4{mem_cyc}} & mid_hit);
      // Peripheral selects serve memory and I/O cycles alike
      if (ctrl_reg[csm_pkg::CTRL_ADDR_OUT]) begin
        periph_select_n <= {bus_addr[2], bus_addr[1], ~per_hit[4:0]};
      end else begin
        periph_select_n <= ~per_hit;
      end
    end
  end

  // Fresh decode on a start edge, so mid pins switch with the others
  assign mid_now = bus_start ? ~({4{mem_cyc}} & mid_hit) : mid_drive;
  // Mid pins 0, 1 and 3 repurposed in enhanced mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mid_sel_n   <= 4'hF;
      copro_req   <= 1'b0;
      copro_fault <= 1'b0;
    end else if (clk_en) begin
      copro_req   <= enh_reg && copro_req_in;
      copro_fault <= enh_reg && !copro_fault_n_in;
      mid_sel_n   <= enh_reg ? {!numeric_sel_req, mid_now[2], 2'b11}
                             : mid_now;
    end
  end

  // Queue status muxed onto ale and write pins; coprocessor not needed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ale_pin  <= 1'b0;
      wr_n_pin <= 1'b1;
    end else if (clk_en) begin
      ale_pin  <= queue_reg ? queue_status0 : core_ale;
      wr_n_pin <= queue_reg ? queue_status1 : core_wr_n;
    end
  end

  logic ready_int;
  csm_wait u_wait (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .cyc_start  (bus_start),
    .selected   (mem_cyc && (upper_hit || lower_hit || (|mid_hit) || (|per_hit))),
    .wait_count (wait_reg),
    .use_ext    (ext_rdy_reg),
    .ext_ready  (ext_ready),
    .ready      (ready_int)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_ready           <= 1'b0;
      enhanced_mode       <= 1'b0;
      queue_mode          <= 1'b0;
      pin_float_test_mode <= 1'b0;
      refresh_enable      <= 1'b0;
      power_save          <= 1'b0;
    end else if (clk_en) begin
      bus_ready           <= ready_int;
      enhanced_mode       <= enh_reg;
      queue_mode          <= queue_reg;
      pin_float_test_mode <= float_reg;
      refresh_enable      <= enh_reg && ctrl_reg[csm_pkg::CTRL_REFRESH];
      power_save          <= enh_reg && ctrl_reg[csm_pkg::CTRL_PWRSAVE];
    end
  end

  logic unused_dma;
  assign unused_dma = bus_is_dma;

  property p_nomatch_high;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && bus_start && !upper_hit && !lower_hit && mid_hit == 4'h0
       && per_hit == 7'h00 && !ctrl_reg[csm_pkg::CTRL_ADDR_OUT])
      |=> (upper_select_n && lower_select_n && mid_drive == 4'hF
           && periph_select_n == 7'h7F);
  endproperty
  a_nomatch_high: assert property (p_nomatch_high) else $error("select low on miss");

  property p_upper_sel;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && bus_start && mem_cyc && upper_hit) |=> !upper_select_n;
  endproperty
  a_upper_sel: assert property (p_upper_sel) else $error("upper select missing");

  property p_top_in_upper;
    @(posedge sys_clk) disable iff (rst)
      (ctrl_reg[0] && upper_size_reg != 16'h0000 && bus_addr == 20'hF_FFFF) |-> upper_hit;
  endproperty
  a_top_in_upper: assert property (p_top_in_upper) else $error("top not in upper");

  property p_zero_in_lower;
    @(posedge sys_clk) disable iff (rst)
      (ctrl_reg[1] && lower_size_reg != 16'h0000 && bus_addr == 20'h0_0000) |-> lower_hit;
  endproperty
  a_zero_in_lower: assert property (p_zero_in_lower) else $error("zero not in lower");

  property p_mid_excl;
    @(posedge sys_clk) disable iff (rst)
      (upper_hit || lower_hit) |-> (mid_hit == 4'h0);
  endproperty
  a_mid_excl: assert property (p_mid_excl) else $error("mid overlaps fixed");

  property p_per_onehot;
    @(posedge sys_clk) disable iff (rst)
      $onehot0(per_hit);
  endproperty
  a_per_onehot: assert property (p_per_onehot) else $error("multi periph");

  property p_addr_out;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && bus_start && ctrl_reg[4]) |=> (periph_select_n[6:5] == $past(bus_addr[2:1]));
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("latched address wrong");

  property p_enh_gate;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && !enh_reg) |=> (!refresh_enable && !power_save && !copro_req);
  endproperty
  a_enh_gate: assert property (p_enh_gate) else $error("enhanced leak");

  property p_queue_mux;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && queue_reg) |=> (ale_pin == $past(queue_status0) && wr_n_pin == $past(queue_status1));
  endproperty
  a_queue_mux: assert property (p_queue_mux) else $error("queue status mux");

  property p_float_stable;
    @(posedge sys_clk) disable iff (rst)
      (strap_reg == csm_pkg::ST_RUN) |=> $stable(float_reg);
  endproperty
  a_float_stable: assert property (p_float_stable) else $error("float changed");
endmodule

// ---- core/csm_wait.sv ----
/*
  Ready generator: counts programmed wait states for a decoded access.
  Assumes cyc_start is a one-cycle pulse and ext_ready is synchronous.
*/
`timescale 1ns/1ns
module csm_wait (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       cyc_start,
  input  wire logic       selected,
  input  wire logic [3:0] wait_count,
  input  wire logic       use_ext,
  input  wire logic       ext_ready,
  output logic            ready
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 4'h0;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      if (cyc_start && selected) begin
        cnt_reg  <= wait_count;
        busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg && (!use_ext || ext_ready)) begin
        busy_reg <= 1'b0;
      end
    end
  end
  // Ready once programmed waits elapsed; external ready also honoured when asked
  assign ready = busy_reg && cnt_reg == 4'h0 && (!use_ext || ext_ready);
endmodule

// ---- verification/csm_partner.sv ----
/*
  Board model: strap pulls and coprocessor lines.
  Assumes the bench picks the strap levels before reset is applied.
*/
`timescale 1ns/1ns
module csm_partner (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enh,
  input  wire logic que,
  input  wire logic flt,
  input  wire logic req,
  input  wire logic fault,
  output logic      strap_busy_n,
  output logic      strap_rd_n,
  output logic      strap_upper_n,
  output logic      strap_lower_n,
  output logic      copro_req_in,
  output logic      copro_fault_n_in
);
  logic [1:0] hold_reg;
  logic       strap_on;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hold_reg <= 2'h0;
    else if (hold_reg != 2'h3) hold_reg <= hold_reg + 2'h1;
  end
  // Straps held until the second edge after release, then pull-ups win
  assign strap_on = rst || (hold_reg < 2'h2);
  assign strap_busy_n = !(enh && strap_on);
  assign strap_rd_n = !(que && strap_on);
  assign strap_upper_n = !(flt && strap_on);
  assign strap_lower_n = !(flt && strap_on);
  assign copro_req_in = req;
  assign copro_fault_n_in = !fault;
endmodule

// ---- verification/csm_top_tb.sv ----
/*
  Self-checking bench for the select decoder and strap capture.
  Assumes csm_top and csm_partner are compiled before it.
*/
`timescale 1ns/1ns
module csm_top_tb;
  logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, rdv;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, bus_start = 1'b0, bus_is_mem = 1'b1;
  logic        bus_is_dma = 1'b0, ext_ready = 1'b0, core_ale = 1'b0, core_wr_n = 1'b1;
  logic        queue_status0 = 1'b1, queue_status1 = 1'b0, numeric_sel_req = 1'b0;
  logic        enh = 1'b0, que = 1'b0, flt = 1'b0, req = 1'b0, fault = 1'b0;
  logic [19:0] bus_addr = 20'h0_0000;
  logic [12:0] sel;
  wire         strap_busy_n, strap_rd_n, strap_upper_n, strap_lower_n;
  wire         copro_req_in, copro_fault_n_in;
  logic [15:0] reg_rdata;
  logic [3:0]  mid_sel_n;
  logic [6:0]  periph_select_n;
  logic        upper_select_n, lower_select_n, ale_pin, wr_n_pin, copro_req, copro_fault;
  logic        bus_ready, enhanced_mode, queue_mode, pin_float_test_mode;
  logic        refresh_enable, power_save;
  int          fail_count = 0, n_compared = 0, cycles = 0, n, i;

  csm_top i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_addr(bus_addr), .bus_start(bus_start), .bus_is_mem(bus_is_mem),
    .bus_is_dma(bus_is_dma), .ext_ready(ext_ready), .strap_busy_n(strap_busy_n),
    .strap_rd_n(strap_rd_n), .strap_upper_n(strap_upper_n), .strap_lower_n(strap_lower_n),
    .copro_req_in(copro_req_in), .copro_fault_n_in(copro_fault_n_in),
    .numeric_sel_req(numeric_sel_req), .core_ale(core_ale), .core_wr_n(core_wr_n),
    .queue_status0(queue_status0), .queue_status1(queue_status1),
    .upper_select_n(upper_select_n), .lower_select_n(lower_select_n),
    .mid_sel_n(mid_sel_n), .periph_select_n(periph_select_n), .ale_pin(ale_pin),
    .wr_n_pin(wr_n_pin), .copro_req(copro_req), .copro_fault(copro_fault),
    .bus_ready(bus_ready), .enhanced_mode(enhanced_mode), .queue_mode(queue_mode),
    .pin_float_test_mode(pin_float_test_mode), .refresh_enable(refresh_enable),
    .power_save(power_save));
  csm_partner i_board (.sys_clk(sys_clk), .rst(rst), .enh(enh), .que(que), .flt(flt),
    .req(req), .fault(fault), .strap_busy_n(strap_busy_n), .strap_rd_n(strap_rd_n),
    .strap_upper_n(strap_upper_n), .strap_lower_n(strap_lower_n),
    .copro_req_in(copro_req_in), .copro_fault_n_in(copro_fault_n_in));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data exist only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask
  // Starts spaced widely so the ready counter always drains
  task automatic cyc(input logic [19:0] a, input logic m);
    @(posedge sys_clk);
    bus_start <= 1'b1;
    bus_addr <= a;
    bus_is_mem <= m;
    @(posedge sys_clk);
    bus_start <= 1'b0;
    #1;
    sel = {upper_select_n, lower_select_n, mid_sel_n, periph_select_n};
    n = 0;
    while (bus_ready !== 1'b1 && n < 15) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic e, input logic q, input logic f);
    @(posedge sys_clk);
    rst <= 1'b1;
    enh <= e;
    que <= q;
    flt <= f;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_regs;
    chk(ale_pin, 1'b0);
    chk(wr_n_pin, 1'b1);
    rd(csm_pkg::OFF_UPPER_SIZE);
    chk(rdv, 16'h0040);
    rd(4'hF);
    chk(rdv, 16'h0000);
    wr(csm_pkg::OFF_CTRL, 16'h007F);
    rd(csm_pkg::OFF_CTRL);
    chk(rdv, 16'h001F);
    chk(refresh_enable, 1'b0);
    wr(csm_pkg::OFF_CTRL, 16'h000F);
  endtask
  task automatic t_fixed;
    cyc(20'hF_FFF0, 1'b1);
    chk(sel, 13'h0FFF);
    cyc(20'hF_0000, 1'b1);
    chk(sel, 13'h0FFF);
    cyc(20'hE_FFFF, 1'b1);
    chk(sel, 13'h1FFF);
    cyc(20'hF_FFF0, 1'b0);
    chk(sel, 13'h1FFF);
    bus_is_dma <= 1'b1;
    cyc(20'hF_FFF0, 1'b1);
    chk(sel, 13'h0FFF);
    bus_is_dma <= 1'b0;
    wr(csm_pkg::OFF_LOWER_SIZE, 16'h0001);
    cyc(20'h0_0000, 1'b1);
    chk(sel, 13'h17FE);
    cyc(20'h0_03FF, 1'b1);
    chk(sel, 13'h17FF);
    cyc(20'h0_0400, 1'b1);
    chk(sel, 13'h1FFF);
  endtask
  task automatic t_mid;
    for (i = 0; i < 4; i++) begin
      wr(csm_pkg::OFF_MID_SEL, 16'(i));
      wr(csm_pkg::OFF_MID_BASE, 16'(32 + 8 * i));
      wr(csm_pkg::OFF_MID_SIZE, 16'h0004);
    end
    for (i = 0; i < 4; i++) begin
      cyc(20'((32 + 8 * i) * 1024), 1'b1);
      chk(sel, 13'h1FFF & ~(13'h0080 << i));
      cyc(20'((36 + 8 * i) * 1024 - 1), 1'b1);
      chk(sel, 13'h1FFF & ~(13'h0080 << i));
      cyc(20'((36 + 8 * i) * 1024), 1'b1);
      chk(sel, 13'h1FFF);
    end
  endtask
  task automatic t_periph;
    wr(csm_pkg::OFF_PER_BASE, 16'h0400);
    for (i = 0; i < 8; i++) begin
      cyc(20'h2_0000 + 20'(i * 128 + 4), 1'b1);
      chk(sel, (i == 7) ? 13'h1FFF : 13'h1FFF & ~(13'h0001 << i));
    end
    wr(csm_pkg::OFF_CTRL, 16'h001F);
    cyc(20'h2_0004, 1'b1);
    chk(periph_select_n, 7'h5E);
  endtask
  task automatic t_ready;
    wr(csm_pkg::OFF_WAIT, 16'h0002);
    cyc(20'hF_FFF0, 1'b1);
    chk(n, 3);
    wr(csm_pkg::OFF_WAIT, 16'h0011);
    cyc(20'hF_FFF0, 1'b1);
    chk(n, 15);
    ext_ready <= 1'b1;
    cyc(20'hF_FFF0, 1'b1);
    chk(n, 2);
  endtask
  task automatic t_enhanced;
    do_reset(1'b1, 1'b0, 1'b0);
    chk(enhanced_mode, 1'b1);
    wr(csm_pkg::OFF_CTRL, 16'h0061);
    rd(csm_pkg::OFF_CTRL);
    chk(rdv, 16'h0061);
    chk({refresh_enable, power_save}, 2'b11);
    @(posedge sys_clk);
    req <= 1'b1;
    fault <= 1'b1;
    numeric_sel_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({copro_req, copro_fault}, 2'b11);
    chk(mid_sel_n, 4'h7);
  endtask
  task automatic t_straps;
    do_reset(1'b0, 1'b1, 1'b0);
    chk({queue_mode, enhanced_mode}, 2'b10);
    chk({ale_pin, wr_n_pin}, 2'b10);
    do_reset(1'b0, 1'b0, 1'b1);
    chk(pin_float_test_mode, 1'b1);
    rd(csm_pkg::OFF_STATUS);
    chk(rdv, 16'h0004);
    do_reset(1'b0, 1'b0, 1'b0);
    chk(pin_float_test_mode, 1'b0);
  endtask

  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    t_regs();
    t_fixed();
    t_mid();
    t_periph();
    t_ready();
    t_enhanced();
    t_straps();
    tally_and_finish();
  end
endmodule
